// ==== verilog/usf_suspend_frame.sv ====
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Suspended flag is set by hardware when the controller enters suspend.
// [RULE2] Suspended flag clears on resume written zero, or common read after resume.
// [RULE3] Resume control set while suspended drives resume signalling; software ends it.
// [RULE4] Suspend detect enable gates whether bus suspend signalling is acted on.
// [RULE5] Low byte of last received frame number is read-only.
// [RULE6] Pending flags are read-only; enables live in separate registers.
// [RULE7] Interrupt request is high while any pending flag is one.
// [RULE8] System interrupt enable outside this block gates the request to the CPU.
// [RULE9] Reading a flag register returns the flags and clears them all; the code clears only the flags captured in the read data at setup.
// [RULE10] IN flags: endpoint 3 bit 3, 2 bit 2, 1 bit 1, control bit 0.
// [RULE11] Bits 7 to 4 of the IN flag register read zero, writes ignored.
// [RULE12] IN flags clear on read and reset to all zeros.
// [RULE13] Inhibit bit is one after power-on or USB reset.
// [RULE14] Software writes of one to the inhibit bit are ignored.
module usf_suspend_frame
   import usf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bus_suspend_seen,
   input wire logic bus_resume_seen,
   input wire logic bus_reset_seen,
   input wire logic sof_seen,
   input wire logic [10:0] frame_number,
   input wire logic [3:0] in_flag_set,
   output logic resume_drive,
   output logic usb_inhibit,
   output logic usb_irq
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [2:0] sus_sync;
      logic [2:0] res_sync;
      logic [2:0] rst_sync;
      logic sus_level;
      logic res_level;
      logic rst_level;
      logic suspend_en;
      logic suspended;
      logic resume_force;
      logic inhibit;
      logic resume_pending;
      logic [7:0] frame_low;
      logic [3:0] in_flags;
      logic [3:0] cm_flags;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic irq;
   } usf_state_s;

   usf_state_s st_r;
   usf_state_s st_nxt;
   logic setup_rd;
   logic wr_acc;
   logic rd_acc;
   logic sus_edge;
   logic res_edge;
   logic rst_edge;
   logic hit;

   always_comb begin
      st_nxt = st_r;
      setup_rd = psel && !penable && !pwrite;
      wr_acc = psel && penable && pwrite && st_r.pready;
      rd_acc = psel && penable && !pwrite && st_r.pready;
      hit = (paddr == USF_POWER_OFS) || (paddr == USF_FRAME_LOW_OFS) ||
            (paddr == USF_IN_IRQ_OFS) || (paddr == USF_COMMON_IRQ_OFS) ||
            (paddr == USF_IRQ_STATUS_OFS) || (paddr == USF_IRQ_MASK_OFS);
      // Pin inputs pass three flops; a change counts when the last two agree.
      st_nxt.sus_sync = {st_r.sus_sync[1:0], bus_suspend_seen};
      st_nxt.res_sync = {st_r.res_sync[1:0], bus_resume_seen};
      st_nxt.rst_sync = {st_r.rst_sync[1:0], bus_reset_seen};
      if (st_r.sus_sync[2] == st_r.sus_sync[1]) begin
         st_nxt.sus_level = st_r.sus_sync[2];
      end
      if (st_r.res_sync[2] == st_r.res_sync[1]) begin
         st_nxt.res_level = st_r.res_sync[2];
      end
      if (st_r.rst_sync[2] == st_r.rst_sync[1]) begin
         st_nxt.rst_level = st_r.rst_sync[2];
      end
      sus_edge = st_nxt.sus_level && !st_r.sus_level;
      res_edge = st_nxt.res_level && !st_r.res_level;
      rst_edge = st_nxt.rst_level && !st_r.rst_level;

      st_nxt.frame_low = frame_number[7:0]; // [RULE5]
      st_nxt.pready = psel && !penable;
      st_nxt.pslverr = psel && !penable && !hit;

      // Read data is fetched in the setup cycle, so read clears happen at the access edge.
      if (setup_rd) begin
         st_nxt.prdata = 32'h0000_0000;
         case (paddr)
            USF_POWER_OFS: begin
               st_nxt.prdata[USF_SUSPEND_EN_BIT] = st_r.suspend_en;
               st_nxt.prdata[USF_SUSPENDED_BIT] = st_r.suspended;
               st_nxt.prdata[USF_RESUME_BIT] = st_r.resume_force;
               st_nxt.prdata[USF_BUS_RESET_BIT] = st_r.rst_level;
               st_nxt.prdata[USF_INHIBIT_BIT] = st_r.inhibit;
            end
            USF_FRAME_LOW_OFS: st_nxt.prdata[7:0] = st_r.frame_low; // [RULE5]
            USF_IN_IRQ_OFS: st_nxt.prdata[3:0] = st_r.in_flags; // [RULE10] [RULE11]
            USF_COMMON_IRQ_OFS: st_nxt.prdata[3:0] = st_r.cm_flags;
            USF_IRQ_STATUS_OFS: st_nxt.prdata[2:0] = st_r.irq_status;
            USF_IRQ_MASK_OFS: st_nxt.prdata[2:0] = st_r.irq_mask;
            default: st_nxt.prdata = 32'h0000_0000;
         endcase
      end

      // Read clears the flags returned in the read data; a set in the same cycle still wins.
      // Only flags already captured in the read data are cleared, so a set in setup is kept.
      if (rd_acc && paddr == USF_IN_IRQ_OFS) begin
         st_nxt.in_flags = st_r.in_flags & ~st_r.prdata[3:0]; // [RULE9] [RULE12]
      end
      if (rd_acc && paddr == USF_COMMON_IRQ_OFS) begin
         st_nxt.cm_flags = st_r.cm_flags & ~st_r.prdata[3:0]; // [RULE9]
         if (st_r.resume_pending) begin
            st_nxt.suspended = 1'b0; // [RULE2]
            st_nxt.resume_pending = 1'b0;
         end
      end
      st_nxt.in_flags = st_nxt.in_flags | in_flag_set; // [RULE10]

      if (wr_acc && pstrb[0]) begin
         case (paddr)
            USF_POWER_OFS: begin
               st_nxt.suspend_en = pwdata[USF_SUSPEND_EN_BIT];
               if (pwdata[USF_RESUME_BIT] && st_r.suspended) begin
                  st_nxt.resume_force = 1'b1; // [RULE3]
               end
               if (!pwdata[USF_RESUME_BIT] && st_r.resume_force) begin
                  st_nxt.resume_force = 1'b0;
                  st_nxt.suspended = 1'b0; // [RULE2]
               end
               if (!pwdata[USF_INHIBIT_BIT]) begin
                  st_nxt.inhibit = 1'b0; // [RULE14]
               end
            end
            USF_IRQ_STATUS_OFS: st_nxt.irq_status = st_r.irq_status & ~pwdata[2:0];
            USF_IRQ_MASK_OFS: st_nxt.irq_mask = pwdata[2:0];
            default: st_nxt.irq_mask = st_r.irq_mask;
         endcase
      end

      if (sus_edge && st_r.suspend_en) begin // [RULE4]
         st_nxt.suspended = 1'b1; // [RULE1]
         st_nxt.cm_flags[USF_CM_SUSPEND_BIT] = 1'b1;
         st_nxt.irq_status[USF_EV_SUSPEND] = 1'b1;
      end
      if (res_edge && st_r.suspended) begin
         st_nxt.resume_pending = 1'b1;
         st_nxt.cm_flags[USF_CM_RESUME_BIT] = 1'b1;
         st_nxt.irq_status[USF_EV_RESUME] = 1'b1;
      end
      if (rst_edge) begin
         st_nxt.cm_flags[USF_CM_RESET_BIT] = 1'b1;
         st_nxt.inhibit = 1'b1; // [RULE13]
      end
      if (sof_seen) begin
         st_nxt.cm_flags[USF_CM_SOF_BIT] = 1'b1;
      end
      if (|st_nxt.in_flags) begin
         st_nxt.irq_status[USF_EV_INFLAG] = 1'b1;
      end

      // Request follows the pending flags; the mask sits apart from them.
      st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask) ||
                   |st_nxt.in_flags || |st_nxt.cm_flags; // [RULE6] [RULE7]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.inhibit <= 1'b1; // [RULE13]
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign resume_drive = st_r.resume_force; // [RULE3]
   assign usb_inhibit = st_r.inhibit;
   assign usb_irq = st_r.irq;
endmodule

// ==== verilog/usf_pkg.sv ====
package usf_pkg;
   // Register byte addresses on the APB side.
   localparam logic [7:0] USF_POWER_OFS = 8'h04;
   localparam logic [7:0] USF_FRAME_LOW_OFS = 8'h30;
   localparam logic [7:0] USF_IN_IRQ_OFS = 8'h00;
   localparam logic [7:0] USF_COMMON_IRQ_OFS = 8'h18;
   localparam logic [7:0] USF_IRQ_STATUS_OFS = 8'h40;
   localparam logic [7:0] USF_IRQ_MASK_OFS = 8'h44;
   // Indirect index of the frame byte as the USB core numbers it.
   localparam logic [7:0] USF_FRAME_LOW_IDX = 8'h0C;
   // Power register field positions.
   localparam int USF_SUSPEND_EN_BIT = 0;
   localparam int USF_SUSPENDED_BIT = 1;
   localparam int USF_RESUME_BIT = 2;
   localparam int USF_BUS_RESET_BIT = 3;
   localparam int USF_INHIBIT_BIT = 4;
   localparam logic [7:0] USF_POWER_RESET = 8'h10;
   // Common flag positions.
   localparam int USF_CM_SUSPEND_BIT = 0;
   localparam int USF_CM_RESUME_BIT = 1;
   localparam int USF_CM_RESET_BIT = 2;
   localparam int USF_CM_SOF_BIT = 3;
   localparam logic [3:0] USF_IN_IRQ_RESET = 4'h0;
   // Interrupt status bit positions.
   localparam int USF_EV_SUSPEND = 0;
   localparam int USF_EV_RESUME = 1;
   localparam int USF_EV_INFLAG = 2;
   localparam logic [2:0] USF_MASK_RESET = 3'h0;
endpackage

// ==== bench/usf_checker_properties.sv ====
`timescale 1ns/1ps
module usf_checker
   import usf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic bus_reset_seen,
   input wire logic [10:0] frame_number,
   input wire logic [3:0] in_flag_set,
   input wire logic resume_drive,
   input wire logic usb_inhibit,
   input wire logic usb_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr_acc = psel && penable && pready && pwrite;
   wire logic rd_acc = psel && penable && pready && !pwrite;
   sequence s_in_rd; rd_acc && paddr == USF_IN_IRQ_OFS && in_flag_set == 4'h0; endsequence
   sequence s_in_setup; psel && !penable && !pwrite && paddr == USF_IN_IRQ_OFS; endsequence
   property p_rd_clear;
      (s_in_setup ##0 in_flag_set == 4'h0) ##1 s_in_rd ##1 in_flag_set == 4'h0 ##1 s_in_setup
      |=> prdata == 0;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("IN flags not cleared by read");
   property p_in_high; rd_acc && paddr == USF_IN_IRQ_OFS |-> prdata < 32'h0000_0010; endproperty
   a_in_high: assert property (p_in_high) else $error("IN upper bits not zero");
   property p_irq; in_flag_set != 4'h0 |=> usb_irq; endproperty
   a_irq: assert property (p_irq) else $error("irq missing after flag");
   property p_inh_rst; !$past(presetn) |-> usb_inhibit; endproperty
   a_inh_rst: assert property (p_inh_rst) else $error("inhibit low after reset");
   property p_inh_set;
      wr_acc && paddr == USF_POWER_OFS && !usb_inhibit && !bus_reset_seen |=> !usb_inhibit;
   endproperty
   a_inh_set: assert property (p_inh_set) else $error("inhibit set by write");
   property p_frame;
      rd_acc && paddr == USF_FRAME_LOW_OFS && frame_number == $past(frame_number, 3)
      |-> prdata == 32'(frame_number[7:0]);
   endproperty
   a_frame: assert property (p_frame) else $error("frame byte wrong");
   property p_resume;
      $rose(resume_drive) |-> $past(wr_acc && paddr == USF_POWER_OFS && pwdata[USF_RESUME_BIT]);
   endproperty
   a_resume: assert property (p_resume) else $error("resume without write");
   property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
   a_ready: assert property (p_ready) else $error("pready timing wrong");
endmodule
bind usf_suspend_frame usf_checker usf_checker_inst (.*);

// ==== bench/usf_host_model.sv ====
`timescale 1ns/1ps
module usf_host_model (
   input wire logic pclk,
   output logic bus_suspend_seen,
   output logic bus_resume_seen,
   output logic bus_reset_seen,
   output logic sof_seen,
   output logic [10:0] frame_number
);
   logic [2:0] cond = 3'h0;
   assign {bus_reset_seen, bus_resume_seen, bus_suspend_seen} = cond;
   initial begin
      sof_seen = 0;
      frame_number = 11'h000;
   end
   // Holds a bus condition long enough to pass the receiver's synchroniser.
   task automatic hold(input int k);
      cond[k] <= 1;
      repeat (8) @(posedge pclk);
      cond[k] <= 0;
      repeat (8) @(posedge pclk);
   endtask
   task automatic start_frame(input logic [10:0] n);
      frame_number <= n;
      sof_seen <= 1;
      @(posedge pclk);
      sof_seen <= 0;
   endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench
   import usf_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic bus_suspend_seen, bus_resume_seen, bus_reset_seen, sof_seen;
   logic resume_drive, usb_inhibit, usb_irq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0] pstrb = 4'hF, in_flag_set = 4'h0;
   logic [10:0] frame_number;
   int err_count = 0, n_checks = 0;
   usf_suspend_frame usf_suspend_frame_inst (.*);
   usf_host_model usf_host_model_inst (.*);
   initial begin
      forever #50 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 || n++ < 0);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd, e);
   endtask
   task automatic t_reset;
      chk(usb_inhibit, 1);
      rdchk(USF_POWER_OFS, 32'h0000_0010);
      rdchk(USF_IN_IRQ_OFS, 0);
      apb(1, USF_POWER_OFS, 0);
      apb(1, USF_POWER_OFS, 32'h0000_0010);
      rdchk(USF_POWER_OFS, 0);
      usf_host_model_inst.hold(2);
      chk(usb_inhibit, 1);
      apb(1, USF_POWER_OFS, 0);
      rdchk(USF_COMMON_IRQ_OFS, 32'h0000_0004);
      chk(usb_inhibit, 0);
      apb(0, 8'h80, 0);
      chk(er, 1);
   endtask
   task automatic t_in;
      for (int i = 0; i < 4; i++) begin
         in_flag_set <= 4'h1 << i;
         @(posedge pclk);
         in_flag_set <= 4'h0;
         @(negedge pclk);
         chk(usb_irq, 1);
         @(posedge pclk);
         rdchk(USF_IN_IRQ_OFS, 32'h0000_0001 << i);
         rdchk(USF_IN_IRQ_OFS, 0);
      end
      chk(usb_irq, 0);
      apb(1, USF_IN_IRQ_OFS, 32'h0000_00FF);
      rdchk(USF_IN_IRQ_OFS, 0);
      chk(usb_irq, 0);
   endtask
   task automatic t_frame;
      usf_host_model_inst.start_frame(11'h5A3);
      rdchk(USF_FRAME_LOW_OFS, 32'h0000_00A3);
      apb(1, USF_FRAME_LOW_OFS, 0);
      rdchk(USF_FRAME_LOW_OFS, 32'h0000_00A3);
      rdchk(USF_COMMON_IRQ_OFS, 32'h0000_0008);
   endtask
   task automatic t_susp;
      apb(1, USF_POWER_OFS, 32'h0000_0001);
      usf_host_model_inst.hold(0);
      rdchk(USF_POWER_OFS, 32'h0000_0003);
      rdchk(USF_COMMON_IRQ_OFS, 32'h0000_0001);
      chk(usb_irq, 0);
      apb(1, USF_IRQ_MASK_OFS, 32'h0000_0001);
      chk(usb_irq, 1);
      apb(1, USF_IRQ_STATUS_OFS, 32'h0000_0001);
      chk(usb_irq, 0);
      apb(1, USF_POWER_OFS, 32'h0000_0005);
      chk(resume_drive, 1);
      apb(1, USF_POWER_OFS, 32'h0000_0001);
      chk(resume_drive, 0);
      rdchk(USF_POWER_OFS, 32'h0000_0001);
      usf_host_model_inst.hold(0);
      usf_host_model_inst.hold(1);
      rdchk(USF_POWER_OFS, 32'h0000_0003);
      rdchk(USF_COMMON_IRQ_OFS, 32'h0000_0003);
      rdchk(USF_POWER_OFS, 32'h0000_0001);
      apb(1, USF_POWER_OFS, 0);
      usf_host_model_inst.hold(0);
      rdchk(USF_POWER_OFS, 0);
   endtask
   task automatic results;
      $display("errors %0d checks %0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_in;
      t_frame;
      t_susp;
      results;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      results;
   end
endmodule
